// [design/bfc_pkg.sv]
// Purpose: constants for the bridge forwarding control block
// Assumes: 32-bit configuration dwords, byte enables active low
// Notes:   offsets are byte addresses of configuration dwords
`default_nettype none
package bfc_pkg;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0]  OFS_IO_LIMIT   = 8'h30; // io window top upper
	localparam logic [7:0]  OFS_CAP_PTR    = 8'h34; // capability pointer
	localparam logic [7:0]  OFS_BRIDGE_CTL = 8'h3c; // pin byte and control
	// ---------------------------------------------------------------
	// fixed values and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0]  CAP_PTR_VALUE  = 8'hdc; // power mgmt offset
	localparam logic [7:0]  INT_PIN_VALUE  = 8'h00; // no interrupt pin
	localparam logic [15:0] IO_LIMIT_RST   = 16'h0000;
	localparam logic [15:0] CTL_RST        = 16'h0000;
	// control bits inside the upper half of dword 0x3c
	localparam int          BIT_PARITY     = 0;  // dword bit 16
	localparam int          BIT_SERR_FWD   = 1;  // dword bit 17
	localparam int          BIT_ISA        = 2;  // dword bit 18
	localparam int          BIT_VGA        = 3;  // dword bit 19
	localparam int          BIT_ABORT      = 5;  // dword bit 21
	localparam int          BIT_SEC_RST    = 6;  // dword bit 22
	localparam logic [15:0] CTL_WMASK      = 16'h006f; // bit 20 reserved
	// ---------------------------------------------------------------
	// decode constants
	// ---------------------------------------------------------------
	localparam logic [15:0] ISA_SPACE_TOP  = 16'h0000; // first 64 kB
	localparam logic [31:0] VGA_MEM_LO     = 32'h000a0000;
	localparam logic [31:0] VGA_MEM_HI     = 32'h000bffff;
	localparam logic [9:0]  VGA_IO1_LO     = 10'h3b0;
	localparam logic [9:0]  VGA_IO1_HI     = 10'h3bb;
	localparam logic [9:0]  VGA_IO2_LO     = 10'h3c0;
	localparam logic [9:0]  VGA_IO2_HI     = 10'h3df;
	localparam logic [31:0] ABORT_RDATA    = 32'hffffffff;
endpackage : bfc_pkg
`default_nettype wire

// [design/bfc_bridge_forwarding_control.sv]
// Purpose: bridge control registers and the forwarding decisions they steer
// Assumes: one pci clock, synchronous active-low primary reset
// Notes:   io base upper half and lower io window bits come in as inputs
//
// Functional notes
// - writable io window top upper 16 bits
// - capability pointer reads fixed dc
// - capability dword upper 24 bits zero
// - interrupt pin byte reads zero
// - parity bit clear blocks parity reporting
// - parity bit set enables parity reporting
// - forward secondary system error when enabled
// - isa clear forwards whole io window
// - isa set drops top 768 bytes
// - isa set forwards top 768 upstream
// - vga clear ignores vga unless window
// - vga set forwards frame buffer memory
// - vga set forwards legacy video io
// - vga needs enables, ignored on secondary
// - bit 20 reserved reads zero
// - abort clear completes with all ones
// - abort set gives target abort, serr
// - secondary reset output follows control bit
// - secondary reset clears secondary side only
// - byte enables select fields individually
`default_nettype none
module bfc_bridge_forwarding_control
	import bfc_pkg::*;
(
	input  wire logic        clock,          // pci clock
	input  wire logic        rst_n,          // primary reset
	// configuration access
	input  wire logic        cfgWrite,       // config write data phase
	input  wire logic        cfgRead,        // config read data phase
	input  wire logic [7:0]  cfgOffset,      // dword byte address
	input  wire logic [3:0]  upstream_command_byte_enable_n, // lanes
	input  wire logic [31:0] cfgWdata,       // write data
	output logic      [31:0] cfgRdata,       // read data
	// command register and window inputs
	input  wire logic        ioSpaceEn,      // command io enable
	input  wire logic        memSpaceEn,     // command memory enable
	input  wire logic        serrEn,         // command serr enable
	input  wire logic [31:0] ioBase,         // io window bottom
	input  wire logic [15:0] ioLimitLow,     // low half of window top
	// primary transaction decode
	input  wire logic        priValid,       // primary address phase
	input  wire logic        priIsIo,        // 1 io, 0 memory
	input  wire logic [31:0] priAddr,        // primary address
	output logic             priForward,     // claim and forward down
	// secondary transaction decode
	input  wire logic        secValid,       // secondary address phase
	input  wire logic        secIsIo,        // 1 io, 0 memory
	input  wire logic [31:0] secAddr,        // secondary address
	output logic             secForward,     // claim and forward up
	// error handling
	input  wire logic        secDataPerr,    // secondary data parity error
	input  wire logic        secAddrPerr,    // secondary address parity err
	input  wire logic        downstream_system_error_n, // secondary serr
	output logic             downstream_parity_error_n, // secondary perr
	output logic             dataParityReported, // status set pulse
	output logic             upstream_system_error_n,   // primary serr
	// master abort handling
	input  wire logic        masterAbort,    // bridge-initiated abort
	input  wire logic        abortPosted,    // 1 posted write, 0 delayed
	output logic             abortComplete,  // finish with trdy
	output logic             abortTarget,    // signal target abort
	output logic      [31:0] abortRdata,     // read data on completion
	// secondary reset
	output logic             secResetActive_n, // secondary reset pin
	output logic             secLogicReset   // reset for secondary side
);
	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	logic [15:0] ioLimitHigh_reg;  // io window top upper half
	logic [15:0] ctl_reg;          // bridge behaviour control
	logic [15:0] ctl_next;         // merged write value
	logic        hitLimit;         // access to dword 0x30
	logic        hitCtl;           // access to dword 0x3c
	logic [31:0] ioLimit;          // full io window top

	assign hitLimit = cfgOffset == OFS_IO_LIMIT;
	assign hitCtl   = cfgOffset == OFS_BRIDGE_CTL;

	// merge only the enabled upper lanes into control
	always_comb begin
		ctl_next = ctl_reg;
		if (!upstream_command_byte_enable_n[2]) begin
			ctl_next[7:0] = cfgWdata[23:16];
		end
		if (!upstream_command_byte_enable_n[3]) begin
			ctl_next[15:8] = cfgWdata[31:24];
		end
		ctl_next = ctl_next & CTL_WMASK;
	end

	// io window top upper half, lanes 2 and 3
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ioLimitHigh_reg <= IO_LIMIT_RST;
		end else if (cfgWrite && hitLimit) begin
			if (!upstream_command_byte_enable_n[2]) begin
				ioLimitHigh_reg[7:0] <= cfgWdata[23:16];
			end
			if (!upstream_command_byte_enable_n[3]) begin
				ioLimitHigh_reg[15:8] <= cfgWdata[31:24];
			end
		end
	end

	// control register, effective from the next cycle on
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctl_reg <= CTL_RST;
		end else if (cfgWrite && hitCtl) begin
			ctl_reg <= ctl_next;
		end
	end

	// 4 kB granularity: low 12 bits of top are all ones
	assign ioLimit = {ioLimitHigh_reg, ioLimitLow[15:12],
		12'hfff};

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	// registered read data; unmapped dwords return zero
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cfgRdata <= 32'h00000000;
		end else if (cfgRead) begin
			unique case (cfgOffset)
				OFS_IO_LIMIT:   cfgRdata <= {ioLimitHigh_reg, 16'h0000};
				OFS_CAP_PTR:    cfgRdata <= {24'h000000,
					CAP_PTR_VALUE};
				OFS_BRIDGE_CTL: cfgRdata <= {ctl_reg,
					INT_PIN_VALUE, 8'h00};
				default:        cfgRdata <= 32'h00000000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	logic inWindow;   // primary io address inside the window
	logic isaTop;     // top 768 bytes of a 1 kB block
	logic isaDrop;    // isa alias to be ignored on primary
	logic vgaMem;     // legacy frame buffer
	logic vgaIo;      // legacy video io ranges
	logic vgaOk;      // legacy video forwarding allowed
	logic secIsaTop;  // secondary io in top 768 bytes

	assign inWindow  = priAddr >= ioBase && priAddr <= ioLimit;
	assign isaTop    = priAddr[9:8] != 2'b00;
	assign isaDrop   = ctl_reg[BIT_ISA] && priAddr[31:16] == ISA_SPACE_TOP
		&& isaTop;
	assign vgaMem    = priAddr >= VGA_MEM_LO && priAddr <= VGA_MEM_HI;
	assign vgaIo     = priAddr[31:16] == 16'h0000 &&
		((priAddr[9:0] >= VGA_IO1_LO && priAddr[9:0] <= VGA_IO1_HI) ||
		 (priAddr[9:0] >= VGA_IO2_LO && priAddr[9:0] <= VGA_IO2_HI));
	assign vgaOk     = ctl_reg[BIT_VGA] && ioSpaceEn && memSpaceEn;
	assign secIsaTop = secAddr[9:8] != 2'b00;

	// primary forwarding decision
	always_comb begin
		priForward = 1'b0;
		if (priValid) begin
			if (vgaOk && (priIsIo ? vgaIo : vgaMem)) begin
				priForward = 1'b1;
			end else if (priIsIo && ioSpaceEn && inWindow) begin
				// vga clear: vga io forwarded only via window, isa 0
				priForward = !isaDrop;
			end
		end
	end

	// secondary upstream decision; vga addresses never go up while the vga bit is set
	always_comb begin
		secForward = 1'b0;
		if (secValid && secIsIo && ctl_reg[BIT_ISA] && secIsaTop) begin
			secForward = 1'b1;
		end
		if (secValid && ctl_reg[BIT_VGA] && (secIsIo ?
			(secAddr[31:16] == 16'h0000 &&
			((secAddr[9:0] >= VGA_IO1_LO && secAddr[9:0] <= VGA_IO1_HI) ||
			 (secAddr[9:0] >= VGA_IO2_LO && secAddr[9:0] <= VGA_IO2_HI)))
			: (secAddr >= VGA_MEM_LO && secAddr <= VGA_MEM_HI))) begin
			secForward = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// parity and system error
	// ---------------------------------------------------------------
	logic serrSync1;  // synchroniser stage one
	logic serrSync2;  // stage two
	logic serrSync3;  // stage three
	logic secSerrSeen; // stable asserted secondary serr

	// secondary serr arrives from a pin: three stages
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			serrSync1 <= 1'b0;
			serrSync2 <= 1'b0;
			serrSync3 <= 1'b0;
			secSerrSeen <= 1'b0;
		end else begin
			serrSync1 <= !downstream_system_error_n;
			serrSync2 <= serrSync1;
			serrSync3 <= serrSync2;
			if (serrSync2 == serrSync3) begin
				secSerrSeen <= serrSync3;
			end
		end
	end

	// parity reporting gated by parity response bit
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			downstream_parity_error_n <= 1'b1;
			dataParityReported <= 1'b0;
		end else begin
			downstream_parity_error_n <=
				!(ctl_reg[BIT_PARITY] && secDataPerr);
			dataParityReported <= ctl_reg[BIT_PARITY] && secDataPerr;
		end
	end

	// primary serr from forwarded serr, address parity, posted abort
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			upstream_system_error_n <= 1'b1;
		end else begin
			upstream_system_error_n <= !(serrEn && (
				(ctl_reg[BIT_SERR_FWD] && secSerrSeen) ||
				(ctl_reg[BIT_PARITY] && secAddrPerr) ||
				(ctl_reg[BIT_ABORT] && masterAbort &&
				abortPosted)));
		end
	end

	// ---------------------------------------------------------------
	// master abort response
	// ---------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			abortComplete <= 1'b0;
			abortTarget <= 1'b0;
			abortRdata <= 32'h00000000;
		end else begin
			abortComplete <= masterAbort && !abortPosted &&
				!ctl_reg[BIT_ABORT];
			abortTarget <= masterAbort && !abortPosted &&
				ctl_reg[BIT_ABORT];
			abortRdata <= (masterAbort && !ctl_reg[BIT_ABORT]) ?
				ABORT_RDATA : 32'h00000000;
		end
	end

	// ---------------------------------------------------------------
	// secondary reset
	// ---------------------------------------------------------------
	assign secResetActive_n = !ctl_reg[BIT_SEC_RST];
	assign secLogicReset = ctl_reg[BIT_SEC_RST] || !rst_n;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_sec_reset_pin: assert property (
		@(posedge clock) disable iff (!rst_n)
		cfgWrite && hitCtl && !upstream_command_byte_enable_n[2]
		|=> secResetActive_n == !$past(cfgWdata[22]))
		else $error("secondary reset pin mismatch");
	a_ctl_lanes_off: assert property (
		@(posedge clock) disable iff (!rst_n)
		cfgWrite && hitCtl && upstream_command_byte_enable_n[3:2] == 2'b11
		|=> $stable(ctl_reg))
		else $error("control written with lanes off");
	a_limit_lane: assert property (
		@(posedge clock) disable iff (!rst_n)
		cfgWrite && hitLimit && !upstream_command_byte_enable_n[3]
		|=> ioLimitHigh_reg[15:8] == $past(cfgWdata[31:24]))
		else $error("window top lane not written");
	a_perr_gated: assert property (
		@(posedge clock) disable iff (!rst_n)
		!ctl_reg[BIT_PARITY] && secDataPerr
		|=> downstream_parity_error_n)
		else $error("perr driven while response off");
	a_dpr_gated: assert property (
		@(posedge clock) disable iff (!rst_n)
		!ctl_reg[BIT_PARITY]
		|=> !dataParityReported)
		else $error("parity reported while response off");
	a_perr_driven: assert property (
		@(posedge clock) disable iff (!rst_n)
		ctl_reg[BIT_PARITY] && secDataPerr
		|=> !downstream_parity_error_n)
		else $error("perr not driven");
	a_serr_fwd_off: assert property (
		@(posedge clock) disable iff (!rst_n)
		!ctl_reg[BIT_SERR_FWD] && !secAddrPerr && !masterAbort
		|=> upstream_system_error_n)
		else $error("serr forwarded while disabled");
	a_abort_ones: assert property (
		@(posedge clock) disable iff (!rst_n)
		masterAbort && !ctl_reg[BIT_ABORT]
		|=> abortRdata == ABORT_RDATA)
		else $error("abort data not all ones");
	a_abort_target: assert property (
		@(posedge clock) disable iff (!rst_n)
		masterAbort && !abortPosted && ctl_reg[BIT_ABORT]
		|=> abortTarget && !abortComplete)
		else $error("target abort missing");
	a_cap_ptr_read: assert property (
		@(posedge clock) disable iff (!rst_n)
		cfgRead && cfgOffset == OFS_CAP_PTR
		|=> cfgRdata == 32'h000000dc)
		else $error("capability pointer wrong");
	a_ctl_read: assert property (
		@(posedge clock) disable iff (!rst_n)
		cfgRead && hitCtl
		|=> cfgRdata[20] == 1'b0 && cfgRdata[15:8] == 8'h00)
		else $error("reserved bits not zero");
	a_window_fwd: assert property (
		@(posedge clock) disable iff (!rst_n)
		priValid && priIsIo && ioSpaceEn && !ctl_reg[BIT_ISA]
		&& priAddr >= ioBase && priAddr <= ioLimit |-> priForward)
		else $error("io window not forwarded");
	a_vga_mem_fwd: assert property (
		@(posedge clock) disable iff (!rst_n)
		priValid && !priIsIo && ctl_reg[BIT_VGA] && ioSpaceEn
		&& memSpaceEn && priAddr >= VGA_MEM_LO && priAddr <= VGA_MEM_HI
		|-> priForward)
		else $error("vga memory not forwarded");
	a_vga_off_mem: assert property (
		@(posedge clock) disable iff (!rst_n)
		priValid && !priIsIo && !ctl_reg[BIT_VGA]
		|-> !priForward)
		else $error("memory claimed with vga off");
	a_isa_drop: assert property (
		@(posedge clock) disable iff (!rst_n)
		priValid && priIsIo && ctl_reg[BIT_ISA]
		&& priAddr[31:16] == 16'h0000 && priAddr[9:8] != 2'b00
		&& !(vgaOk && vgaIo) |-> !priForward)
		else $error("isa alias forwarded");
	a_isa_up: assert property (
		@(posedge clock) disable iff (!rst_n)
		secValid && secIsIo && ctl_reg[BIT_ISA] && !ctl_reg[BIT_VGA]
		&& secAddr[9:8] != 2'b00 |-> secForward)
		else $error("isa alias not forwarded up");
	a_sec_vga_off: assert property (
		@(posedge clock) disable iff (!rst_n)
		secValid && secIsIo && ctl_reg[BIT_VGA]
		&& secAddr[31:16] == 16'h0000 && secAddr[9:0] >= VGA_IO1_LO
		&& secAddr[9:0] <= VGA_IO1_HI |-> !secForward)
		else $error("vga io forwarded upstream");
endmodule : bfc_bridge_forwarding_control
`default_nettype wire

// [dv/bfc_secondary_model.sv]
// Purpose: secondary bus stand-in that raises the system error pin
// Assumes: pin has a pull-up, so a released pin reads high
// Notes:   pin moves a few ns after the edge, unrelated to the sampler
`default_nettype none
module bfc_secondary_model #(
	parameter int HOLD = 4                     // low time in cycles
) (
	input  wire logic clock,                     // pci clock
	input  wire logic assertReq,                 // start one error event
	output logic      downstream_system_error_n  // open-drain pin level
);
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------------------------
	// error pin driver
	// ---------------------------------------------------------------
	int left = 0;                                // cycles still held low
	initial downstream_system_error_n = 1'b1;    // released at start
	// hold low for HOLD cycles, then let the pull-up win
	always @(posedge clock) begin
		if (assertReq) begin
			left = HOLD;
		end else if (left > 0) begin
			left = left - 1;
		end
		#3 downstream_system_error_n = (left == 0);
	end
endmodule : bfc_secondary_model
`default_nettype wire

// [dv/bfc_bridge_forwarding_control_tb_top.sv]
// Purpose: self-checking bench for the bridge forwarding control block
// Assumes: inputs change 1 ns after the rising edge
// Notes:   window bottom 0, top from limit upper half and ioLimitLow
`default_nettype none
module bfc_bridge_forwarding_control_tb_top import bfc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic clock = 1'b0, rst_n = 1'b0, cfgWrite = 1'b0, cfgRead = 1'b0;
	logic [7:0] cfgOffset = 8'h00;
	logic [3:0] beN = 4'hf;                   // lane enables, low active
	logic [31:0] cfgWdata = 32'h0, cfgRdata, abortRdata, rdSnap;
	logic ioSpaceEn = 1'b1, memSpaceEn = 1'b1, serrEn = 1'b1;
	logic priValid = 1'b0, priIsIo = 1'b0, secValid = 1'b0;
	logic secIsIo = 1'b0, secDataPerr = 1'b0, secAddrPerr = 1'b0;
	logic masterAbort = 1'b0, abortPosted = 1'b0, serrReq = 1'b0;
	logic [31:0] priAddr = 32'h0, secAddr = 32'h0;
	logic priForward, secForward, sSerrN, sPerrN, dpr, pSerrN;
	logic abortComplete, abortTarget, secRstN, secLogicReset;
	logic [7:0] nPerr, nDpr, nSerr, nCmpl, nTgt; // cycles seen active
	int nMismatch = 0, checks = 0;
	// ---------------------------------------------------------------
	// clock, partner and design
	// ---------------------------------------------------------------
	always #10 clock = ~clock;                // 50 MHz
	bfc_secondary_model #(.HOLD(4)) u_sec (.clock(clock),
		.assertReq(serrReq), .downstream_system_error_n(sSerrN));
	bfc_bridge_forwarding_control u_dut (.clock(clock), .rst_n(rst_n),
		.cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgOffset(cfgOffset),
		.upstream_command_byte_enable_n(beN), .cfgWdata(cfgWdata),
		.cfgRdata(cfgRdata), .ioSpaceEn(ioSpaceEn),
		.memSpaceEn(memSpaceEn), .serrEn(serrEn), .ioBase(32'h0),
		.ioLimitLow(16'h1000), .priValid(priValid), .priIsIo(priIsIo),
		.priAddr(priAddr), .priForward(priForward), .secValid(secValid),
		.secIsIo(secIsIo), .secAddr(secAddr), .secForward(secForward),
		.secDataPerr(secDataPerr), .secAddrPerr(secAddrPerr),
		.downstream_system_error_n(sSerrN),
		.downstream_parity_error_n(sPerrN), .dataParityReported(dpr),
		.upstream_system_error_n(pSerrN), .masterAbort(masterAbort),
		.abortPosted(abortPosted), .abortComplete(abortComplete),
		.abortTarget(abortTarget), .abortRdata(abortRdata),
		.secResetActive_n(secRstN), .secLogicReset(secLogicReset));
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic tick();                    // 1 ns past the edge
		@(posedge clock);
		#1;
	endtask : tick
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			nMismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one configuration write data phase
	task automatic wr(input logic [7:0] ofs, input logic [3:0] be,
		input logic [31:0] d);
		{cfgWrite, cfgOffset, beN, cfgWdata} = {1'b1, ofs, be, d};
		tick();
		cfgWrite = 1'b0;
		tick();                               // idle edge between calls
	endtask : wr
	// read, then compare the masked data one cycle later
	task automatic rdchk(input logic [7:0] ofs, input logic [31:0] m,
		input logic [31:0] exp);
		{cfgRead, cfgOffset, beN} = {1'b1, ofs, 4'h0};
		tick();
		cfgRead = 1'b0;
		check(cfgRdata & m, exp);
		tick();                               // idle edge between calls
	endtask : rdchk
	task automatic setCtl(input logic [15:0] v);  // control half only
		wr(OFS_BRIDGE_CTL, 4'b0011, {v, 16'h0});
	endtask : setCtl
	// one decode request held across an edge, compare the claim
	task automatic dec(input logic pri, input logic io,
		input logic [31:0] a, input logic exp);
		{priValid, priIsIo, priAddr} = {pri, io, a};
		{secValid, secIsIo, secAddr} = {!pri, io, a};
		tick();
		check({31'h0, pri ? priForward : secForward}, {31'h0, exp});
	endtask : dec
	// pulse error or abort inputs, then count active output cycles
	task automatic hit(input logic [3:0] sel, input logic posted);
		abortPosted = posted;
		{secDataPerr, secAddrPerr, masterAbort, serrReq} = sel;
		tick();
		rdSnap = abortRdata;
		{secDataPerr, secAddrPerr, masterAbort, serrReq} = 4'h0;
		{nPerr, nDpr, nSerr, nCmpl, nTgt} = '0;
		for (int i = 0; i < 12; i++) begin
			nPerr = nPerr + 8'(sPerrN === 1'b0);
			nDpr = nDpr + 8'(dpr === 1'b1);
			nSerr = nSerr + 8'(pSerrN === 1'b0);
			nCmpl = nCmpl + 8'(abortComplete === 1'b1);
			nTgt = nTgt + 8'(abortTarget === 1'b1);
			tick();
		end
	endtask : hit
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, nMismatch);
		if (nMismatch == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin                             // hang guard
		#1ms;
		nMismatch++;
		complete_run();
	end
	initial begin
		repeat (8) tick();
		rst_n = 1'b1;
		// reset values and fixed fields
		rdchk(OFS_IO_LIMIT, 32'hffff0000, {IO_LIMIT_RST, 16'h0});
		rdchk(OFS_CAP_PTR, 32'hffffffff, {24'h0, CAP_PTR_VALUE});
		rdchk(OFS_BRIDGE_CTL, 32'hffffff00, {CTL_RST, INT_PIN_VALUE, 8'h0});
		// window top and lane selection
		wr(OFS_IO_LIMIT, 4'b0011, 32'h12345678);
		rdchk(OFS_IO_LIMIT, 32'hffff0000, 32'h12340000);
		wr(OFS_IO_LIMIT, 4'b1111, 32'hffffffff);
		rdchk(OFS_IO_LIMIT, 32'hffff0000, 32'h12340000);
		wr(OFS_IO_LIMIT, 4'b0111, 32'hab000000);
		rdchk(OFS_IO_LIMIT, 32'hffff0000, 32'hab340000);
		wr(OFS_CAP_PTR, 4'b0000, 32'hffffffff);
		rdchk(OFS_CAP_PTR, 32'hffffffff, {24'h0, CAP_PTR_VALUE});
		// all ones into control: reserved stays zero, reset pin goes
		wr(OFS_BRIDGE_CTL, 4'b0000, 32'hffffffff);
		rdchk(OFS_BRIDGE_CTL, 32'hffffff00, {CTL_WMASK, 16'h0});
		check({31'h0, secRstN}, 32'h0);
		check({31'h0, secLogicReset}, 32'h1);
		rdchk(OFS_IO_LIMIT, 32'hffff0000, 32'hab340000);
		setCtl(16'h0);
		check({31'h0, secRstN}, 32'h1);
		check({31'h0, secLogicReset}, 32'h0);
		// upper lanes off: control must not move
		wr(OFS_BRIDGE_CTL, 4'b1100, 32'hffffffff);
		rdchk(OFS_BRIDGE_CTL, 32'hffffff00, 32'h0);
		// forwarding decode, window 0 to 1fff
		wr(OFS_IO_LIMIT, 4'b0011, 32'h0);
		dec(1'b1, 1'b1, 32'h100, 1'b1);
		dec(1'b1, 1'b1, 32'h2000, 1'b0);
		dec(1'b1, 1'b1, 32'h3b0, 1'b1);
		dec(1'b1, 1'b0, VGA_MEM_LO, 1'b0);
		dec(1'b0, 1'b1, 32'h100, 1'b0);
		setCtl(16'h1 << BIT_ISA);
		dec(1'b1, 1'b1, 32'h500, 1'b0);
		dec(1'b1, 1'b1, 32'h450, 1'b1);
		dec(1'b1, 1'b1, 32'h3b0, 1'b0);
		dec(1'b0, 1'b1, 32'h100, 1'b1);
		setCtl((16'h1 << BIT_VGA) | (16'h1 << BIT_ISA));
		dec(1'b1, 1'b1, 32'h3c0, 1'b1);
		dec(1'b1, 1'b0, VGA_MEM_LO, 1'b1);
		dec(1'b1, 1'b0, VGA_MEM_HI, 1'b1);
		dec(1'b1, 1'b0, 32'h000c0000, 1'b0);
		dec(1'b1, 1'b1, 32'hf3df, 1'b1);
		dec(1'b1, 1'b1, 32'hf3bc, 1'b0);
		dec(1'b1, 1'b1, 32'h103b0, 1'b0);
		dec(1'b0, 1'b0, VGA_MEM_LO, 1'b0);
		dec(1'b0, 1'b1, 32'h3b0, 1'b0);
		memSpaceEn = 1'b0;
		dec(1'b1, 1'b0, VGA_MEM_LO, 1'b0);
		{memSpaceEn, ioSpaceEn} = 2'b10;
		dec(1'b1, 1'b1, 32'hf3b0, 1'b0);
		ioSpaceEn = 1'b1;
		{priValid, secValid} = 2'b00;         // decode requests end
		// parity reporting off, then on
		setCtl(16'h0);
		hit(4'b1000, 1'b0);
		check(32'(nPerr + nDpr), 32'h0);
		hit(4'b0100, 1'b0);
		check(32'(nSerr), 32'h0);
		setCtl(16'h1 << BIT_PARITY);
		hit(4'b1000, 1'b0);
		check(32'({nPerr, nDpr}), 32'h0101);
		hit(4'b0100, 1'b0);
		check(32'(nSerr != 8'h0), 32'h1);
		// secondary system error forwarding
		setCtl(16'h0);
		hit(4'b0001, 1'b0);
		check(32'(nSerr), 32'h0);
		setCtl(16'h1 << BIT_SERR_FWD);
		hit(4'b0001, 1'b0);
		check(32'(nSerr != 8'h0), 32'h1);
		serrEn = 1'b0;
		hit(4'b0001, 1'b0);
		check(32'(nSerr), 32'h0);
		serrEn = 1'b1;
		// master abort in both modes
		setCtl(16'h0);
		hit(4'b0010, 1'b0);
		check(32'({nCmpl, nTgt}), 32'h0100);
		check(rdSnap, ABORT_RDATA);
		hit(4'b0010, 1'b1);
		check(32'(nSerr), 32'h0);
		setCtl(16'h1 << BIT_ABORT);
		hit(4'b0010, 1'b0);
		check(32'({nCmpl, nTgt}), 32'h0001);
		hit(4'b0010, 1'b1);
		check(32'(nSerr != 8'h0), 32'h1);
		complete_run();
	end
endmodule : bfc_bridge_forwarding_control_tb_top
`default_nettype wire
